// ---- list_scan.sv ----
// Population count and lowest set bit of a register selection mask
`timescale 1ns/1ps

module list_scan #(
  parameter int W = 9,
  parameter int CW = 5,
  parameter int IW = 4
) (
  input wire logic [W-1:0] list,
  output logic [CW-1:0] count,
  output logic [IW-1:0] first,
  output logic any
);

  always_comb
  begin
    count = '0;
    first = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      count = count + {{(CW-1){1'b0}}, list[i]};
      if (list[i])
      begin
        first = IW'(i);
      end
    end
    any = |list;
  end

endmodule : list_scan

// ---- resp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module resp_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] fill;
  } fifo_regs_t;

  fifo_regs_t f_r;
  fifo_regs_t f_nxt;
  logic push;
  logic pop;

  assign in_ready = f_r.fill != (PW+1)'(DEPTH);
  assign out_valid = f_r.fill != '0;
  assign out_data = f_r.mem[f_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    f_nxt = f_r;
    if (push)
    begin
      f_nxt.mem[f_r.wr] = in_data;
      f_nxt.wr = f_r.wr + PW'(1);
    end
    if (pop)
    begin
      f_nxt.rd = f_r.rd + PW'(1);
    end
    if (push && !pop)
    begin
      f_nxt.fill = f_r.fill + (PW+1)'(1);
    end
    else if (pop && !push)
    begin
      f_nxt.fill = f_r.fill - (PW+1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      f_r <= '0;
    else
      f_r <= f_nxt;
  end

endmodule : resp_fifo

// ---- stack_mem_model.sv ----
// Behavioural word memory that answers the sequencer's accesses in order
`timescale 1ns/1ps

module stack_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [31:0] abort_addr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [31:0] rsp_rdata,
  output logic rsp_abort
);
  logic [32:0] pend_q[$];
  logic [31:0] last_r;
  logic keep_r;
  int seed = 16241;

  // Read data is a fixed function of the word address so the bench can predict it
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    mem_word = {a[31:2], 2'b00} ^ 32'h5A5A_C3C3;
  endfunction : mem_word

  initial
  begin
    req_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_rdata = 32'h0000_0000;
    rsp_abort = 1'b0;
    last_r = 32'h0000_0000;
  end

  always @(posedge core_clk)
  begin
    keep_r = rsp_valid && !rsp_ready;
    if (rst)
      pend_q.delete();
    else
    begin
      if (req_valid && req_ready)
        pend_q.push_back({req_addr == abort_addr, req_write ? 32'h0000_0000 : mem_word(req_addr)});
      if (rsp_valid && rsp_ready)
      begin
        last_r = pend_q[0][31:0];
        void'(pend_q.pop_front());
      end
    end
    #1;
    req_ready = !rst && (!slow || $random(seed) % 3 != 0);
    // A raised response holds until taken; an idle bus shows no stale word
    rsp_valid = pend_q.size() != 0 && (keep_r || !slow || $random(seed) % 2 != 0);
    rsp_rdata = rsp_valid ? pend_q[0][31:0] : ~last_r;
    rsp_abort = rsp_valid ? pend_q[0][32] : ~last_r[0];
  end
endmodule : stack_mem_model

// ---- stack_multi_transfer.sv ----
// Stack load-multiple / store-multiple sequencer with pipelined word accesses
`timescale 1ns/1ps

module stack_multi_transfer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic op_is_load,
  input wire logic [stack_xfer_pkg::LIST_W-1:0] reg_list,
  input wire logic extra_flag,
  input wire logic [stack_xfer_pkg::DATA_W-1:0] stack_pointer,
  input wire logic [stack_xfer_pkg::DATA_W-1:0] link_register,
  input wire logic align_check_en,
  output logic [stack_xfer_pkg::REG_IDX_W-1:0] reg_rd_idx,
  input wire logic [stack_xfer_pkg::DATA_W-1:0] reg_rd_data,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_req_write,
  output logic [stack_xfer_pkg::DATA_W-1:0] mem_req_addr,
  output logic [stack_xfer_pkg::DATA_W-1:0] mem_req_wdata,
  input wire logic mem_rsp_valid,
  output logic mem_rsp_ready,
  input wire logic [stack_xfer_pkg::DATA_W-1:0] mem_rsp_rdata,
  input wire logic mem_rsp_abort,
  output logic reg_wr_valid,
  output logic [stack_xfer_pkg::REG_IDX_W-1:0] reg_wr_idx,
  output logic pc_wr_valid,
  output logic [stack_xfer_pkg::DATA_W-1:0] wb_data,
  input wire logic wb_ready,
  output logic sp_wr_en,
  output logic [stack_xfer_pkg::DATA_W-1:0] sp_wr_data,
  output logic op_done,
  output logic op_abort,
  output logic op_align_fault
);

  localparam int DW = stack_xfer_pkg::DATA_W;
  localparam int MW = stack_xfer_pkg::MASK_W;
  localparam int CW = stack_xfer_pkg::CNT_W;
  localparam int IW = stack_xfer_pkg::IDX_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stack_xfer_pkg::xfer_state_t state;
    logic load;
    logic aborted;
    logic [DW-1:0] base;
    logic [DW-1:0] addr;
    logic [DW-1:0] end_addr;
    logic [MW-1:0] issue_mask;
    logic [MW-1:0] drain_mask;
    logic [CW-1:0] total;
    logic [CW-1:0] issued;
    logic [CW-1:0] pending;
    logic req_valid;
    logic req_write;
    logic req_extra;
    logic [CW-1:0] req_num;
    logic [DW-1:0] req_addr;
    logic [DW-1:0] req_wdata;
    logic done;
    logic abort;
    logic fault;
    logic sp_en;
    logic [DW-1:0] sp_data;
  } xfer_regs_t;

  xfer_regs_t s_r;
  xfer_regs_t s_nxt;

  function automatic logic [DW-1:0] byte_span(input logic [CW-1:0] n);
    byte_span = {{(DW-CW){1'b0}}, n} << stack_xfer_pkg::WORD_SHIFT;
  endfunction : byte_span

  function automatic logic [DW-1:0] word_of(input logic [DW-1:0] a);
    word_of = a & ~stack_xfer_pkg::LOW_MASK;
  endfunction : word_of

  // ----------------------------------------------------------------
  // Mask scanning
  // ----------------------------------------------------------------
  logic [CW-1:0] start_cnt;
  logic [CW-1:0] issue_cnt;
  logic [CW-1:0] drain_cnt;
  logic [IW-1:0] start_first;
  logic [IW-1:0] issue_first;
  logic [IW-1:0] drain_first;
  logic start_any;
  logic issue_any;
  logic drain_any;

  list_scan #(.W(MW), .CW(CW), .IW(IW)) u_scan_start (
    .list({extra_flag, reg_list}),
    .count(start_cnt),
    .first(start_first),
    .any(start_any)
  );

  list_scan #(.W(MW), .CW(CW), .IW(IW)) u_scan_issue (
    .list(s_r.issue_mask),
    .count(issue_cnt),
    .first(issue_first),
    .any(issue_any)
  );

  list_scan #(.W(MW), .CW(CW), .IW(IW)) u_scan_drain (
    .list(s_r.drain_mask),
    .count(drain_cnt),
    .first(drain_first),
    .any(drain_any)
  );

  // ----------------------------------------------------------------
  // Response buffer
  // ----------------------------------------------------------------
  // Every response is buffered in issue order, so the register file may
  // stall write-back while the memory keeps streaming answers.
  logic fifo_out_valid;
  logic fifo_pop;
  logic [stack_xfer_pkg::ENTRY_W-1:0] fifo_out;
  logic ent_abort;
  logic drain_write;
  logic drain_extra;
  logic misaligned;
  logic req_fire;
  logic can_issue;

  resp_fifo #(.WIDTH(stack_xfer_pkg::ENTRY_W), .DEPTH(stack_xfer_pkg::FIFO_DEPTH)) u_resp_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(mem_rsp_valid),
    .in_ready(mem_rsp_ready),
    .in_data({mem_rsp_abort, mem_rsp_rdata}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  assign ent_abort = fifo_out[stack_xfer_pkg::ABORT_BIT];
  assign drain_extra = drain_first == stack_xfer_pkg::EXTRA_IDX;
  assign drain_write = s_r.load && !s_r.aborted && !ent_abort;
  assign misaligned = (stack_pointer & stack_xfer_pkg::LOW_MASK) != '0;
  assign req_fire = s_r.req_valid && mem_req_ready;

  // Outstanding accesses never exceed the buffer depth, so a response
  // always finds room once the write-back side drains.
  assign can_issue = !s_r.aborted && issue_any && (!s_r.req_valid || req_fire)
    && (s_r.pending < stack_xfer_pkg::FIFO_LIMIT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.fault = 1'b0;
    s_nxt.sp_en = 1'b0;
    fifo_pop = 1'b0;
    if (req_fire)
    begin
      s_nxt.req_valid = 1'b0;
    end
    case (s_r.state)
      stack_xfer_pkg::ST_IDLE:
      begin
        if (op_valid)
        begin
          if (align_check_en && misaligned)
          begin
            s_nxt.done = 1'b1;
            s_nxt.fault = 1'b1;
          end
          else
          begin
            s_nxt.state = stack_xfer_pkg::ST_RUN;
            s_nxt.load = op_is_load;
            s_nxt.aborted = 1'b0;
            s_nxt.base = stack_pointer;
            s_nxt.addr = word_of(stack_pointer);
            s_nxt.end_addr = word_of(stack_pointer) + byte_span(start_cnt) - stack_xfer_pkg::WORD_BYTES;
            s_nxt.issue_mask = {extra_flag, reg_list};
            s_nxt.drain_mask = {extra_flag, reg_list};
            s_nxt.total = start_cnt;
            s_nxt.issued = '0;
            s_nxt.pending = '0;
          end
        end
      end
      stack_xfer_pkg::ST_RUN:
      begin
        // Write-back side: an aborted or store answer is simply retired
        if (fifo_out_valid && (!drain_write || wb_ready))
        begin
          fifo_pop = 1'b1;
          s_nxt.drain_mask[drain_first] = 1'b0;
          if (ent_abort)
          begin
            s_nxt.aborted = 1'b1;
          end
        end
        // Issue side: lowest selected register first, extra word last
        if (can_issue)
        begin
          s_nxt.req_valid = 1'b1;
          s_nxt.req_write = !s_r.load;
          s_nxt.req_extra = issue_first == stack_xfer_pkg::EXTRA_IDX;
          s_nxt.req_num = s_r.issued;
          s_nxt.req_addr = s_r.addr;
          s_nxt.req_wdata = (issue_first == stack_xfer_pkg::EXTRA_IDX) ? link_register : reg_rd_data;
          s_nxt.issue_mask[issue_first] = 1'b0;
          s_nxt.issued = s_r.issued + stack_xfer_pkg::CNT_ONE;
          s_nxt.addr = s_r.addr + stack_xfer_pkg::WORD_BYTES;
        end
        if (can_issue && !fifo_pop)
        begin
          s_nxt.pending = s_r.pending + stack_xfer_pkg::CNT_ONE;
        end
        else if (fifo_pop && !can_issue)
        begin
          s_nxt.pending = s_r.pending - stack_xfer_pkg::CNT_ONE;
        end
        // After an abort the stack pointer keeps its original value
        if (s_r.pending == '0 && (s_r.aborted || !issue_any))
        begin
          s_nxt.state = stack_xfer_pkg::ST_IDLE;
          s_nxt.done = 1'b1;
          s_nxt.abort = s_r.aborted;
          s_nxt.sp_en = !s_r.aborted;
          s_nxt.sp_data = s_r.base + byte_span(s_r.total);
        end
      end
      default:
      begin
        s_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign op_ready = s_r.state == stack_xfer_pkg::ST_IDLE;
  assign reg_rd_idx = issue_first[stack_xfer_pkg::REG_IDX_W-1:0];
  assign mem_req_valid = s_r.req_valid;
  assign mem_req_write = s_r.req_write;
  assign mem_req_addr = s_r.req_addr;
  assign mem_req_wdata = s_r.req_wdata;
  // Loaded words pass unrotated, whatever the stack pointer's low bits
  assign wb_data = fifo_out[DW-1:0];
  assign reg_wr_idx = drain_first[stack_xfer_pkg::REG_IDX_W-1:0];
  assign reg_wr_valid = (s_r.state == stack_xfer_pkg::ST_RUN) && fifo_out_valid && drain_write
    && !drain_extra;
  assign pc_wr_valid = (s_r.state == stack_xfer_pkg::ST_RUN) && fifo_out_valid && drain_write
    && drain_extra;
  assign sp_wr_en = s_r.sp_en;
  assign sp_wr_data = s_r.sp_data;
  assign op_done = s_r.done;
  assign op_abort = s_r.abort;
  assign op_align_fault = s_r.fault;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence req_taken;
    mem_req_valid && mem_req_ready;
  endsequence

  sequence start_good;
    op_valid && op_ready && !(align_check_en && misaligned);
  endsequence

  sequence start_bad;
    op_valid && op_ready && align_check_en && misaligned;
  endsequence

  sequence fault_answer;
    op_done && op_align_fault && !sp_wr_en && !mem_req_valid;
  endsequence

  sequence clean_finish;
    op_done && !op_abort && !op_align_fault;
  endsequence

  chk_first_addr: assert property (req_taken and (s_r.req_num == '0) |-> mem_req_addr == word_of(s_r.base))
    else $error("first access not at stack pointer");

  chk_addr_step: assert property (req_taken |-> mem_req_addr == word_of(s_r.base) + byte_span(s_r.req_num))
    else $error("access address not previous plus four");

  chk_access_count: assert property (start_good |=> s_r.total == $past(start_cnt) ##0 s_r.issue_mask != '0 || s_r.total == '0)
    else $error("access count differs from selection");

  chk_all_issued: assert property (clean_finish |-> s_r.issued == s_r.total)
    else $error("completed without one access per selected bit");

  chk_end_addr: assert property (clean_finish and (s_r.total != '0)
    |-> s_r.end_addr == s_r.addr - stack_xfer_pkg::WORD_BYTES)
    else $error("end address mismatch");

  chk_sp_update: assert property (sp_wr_en |-> op_done && sp_wr_data == s_r.base + byte_span(s_r.total))
    else $error("stack pointer write-back value wrong");

  chk_pc_last: assert property (pc_wr_valid |-> s_r.load && s_r.drain_mask == stack_xfer_pkg::EXTRA_ONLY)
    else $error("program counter loaded out of order");

  chk_reg_order: assert property (reg_wr_valid && wb_ready |=> !s_r.drain_mask[$past(drain_first)])
    else $error("loaded register not retired in order");

  chk_store_dir: assert property (req_taken |-> mem_req_write == !s_r.load)
    else $error("access direction differs from operation");

  chk_lr_last: assert property (req_taken and s_r.req_extra |-> mem_req_write -> s_r.issue_mask == '0)
    else $error("link register not stored last");

  chk_abort_sp: assert property (op_done && op_abort |-> !sp_wr_en)
    else $error("stack pointer changed after abort");

  chk_word_addr: assert property (mem_req_valid |-> (mem_req_addr & stack_xfer_pkg::LOW_MASK) == '0)
    else $error("access address not word aligned");

  chk_align_fault: assert property (start_bad |=> fault_answer ##1 op_ready)
    else $error("alignment exception not raised");

endmodule : stack_multi_transfer

// ---- stack_xfer_pkg.sv ----
// Constants and types shared by the stack multiple-transfer sequencer
package stack_xfer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int LIST_W = 8;
  localparam int MASK_W = 9;
  localparam int IDX_W = 4;
  localparam int REG_IDX_W = 3;
  localparam int CNT_W = 5;
  localparam int ENTRY_W = 33;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Addressing and encodings
  // ----------------------------------------------------------------
  localparam int WORD_SHIFT = 2;
  localparam logic [31:0] LOW_MASK = 32'h0000_0003;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [3:0] EXTRA_IDX = 4'h8;
  localparam logic [8:0] EXTRA_ONLY = 9'h100;
  localparam logic [4:0] FIFO_LIMIT = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam int ABORT_BIT = 32;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1
  } xfer_state_t;

endpackage : stack_xfer_pkg

// ---- test_stack_multi_transfer.sv ----
// Self-checking bench for the stack multiple-transfer sequencer
`timescale 1ns/1ps

module test_stack_multi_transfer;
  logic core_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_is_load = 1'b0, extra_flag = 1'b0;
  logic align_check_en = 1'b0, wb_ready = 1'b1, slow = 1'b0;
  logic [7:0] reg_list = 8'h00;
  logic [31:0] stack_pointer = 32'h0000_0000, link_register = 32'h0000_0000, abort_addr = 32'hFFFF_FFFF;
  logic op_ready, mem_req_valid, mem_req_ready, mem_req_write, mem_rsp_valid, mem_rsp_ready, mem_rsp_abort;
  logic reg_wr_valid, pc_wr_valid, sp_wr_en, op_done, op_abort, op_align_fault;
  logic [2:0] reg_rd_idx, reg_wr_idx;
  logic [31:0] reg_rd_data, mem_req_addr, mem_req_wdata, mem_rsp_rdata, wb_data, sp_wr_data, last_addr;
  logic [31:0] rf[8];
  logic [3:0] e_idx[9];
  logic e_load = 1'b0;
  logic [31:0] e_base = 32'h0000_0000;
  int seed = 16241, fails = 0, compares = 0, cycles = 0, total = 0, req_n = 0, wb_n = 0, exp_wb = 0;

  always #20 core_clk = ~core_clk;
  assign reg_rd_data = rf[reg_rd_idx];

  stack_multi_transfer dut_u (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
    .op_is_load(op_is_load), .reg_list(reg_list), .extra_flag(extra_flag), .stack_pointer(stack_pointer),
    .link_register(link_register), .align_check_en(align_check_en), .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(reg_rd_data), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_write(mem_req_write), .mem_req_addr(mem_req_addr), .mem_req_wdata(mem_req_wdata),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_ready(mem_rsp_ready), .mem_rsp_rdata(mem_rsp_rdata),
    .mem_rsp_abort(mem_rsp_abort), .reg_wr_valid(reg_wr_valid), .reg_wr_idx(reg_wr_idx),
    .pc_wr_valid(pc_wr_valid), .wb_data(wb_data), .wb_ready(wb_ready), .sp_wr_en(sp_wr_en),
    .sp_wr_data(sp_wr_data), .op_done(op_done), .op_abort(op_abort), .op_align_fault(op_align_fault));

  stack_mem_model mem_u (.core_clk(core_clk), .rst(rst), .slow(slow), .abort_addr(abort_addr),
    .req_valid(mem_req_valid), .req_ready(mem_req_ready), .req_write(mem_req_write), .req_addr(mem_req_addr),
    .rsp_valid(mem_rsp_valid), .rsp_ready(mem_rsp_ready), .rsp_rdata(mem_rsp_rdata), .rsp_abort(mem_rsp_abort));

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic final_report;
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Port monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      final_report();
    end
    if (!rst && mem_req_valid === 1'b1 && mem_req_ready)
    begin
      check_flag("req_in_range", 1'b1, req_n < total);
      if (req_n < total)
      begin
        check_val("req_addr", e_base + 32'(4 * req_n), mem_req_addr);
        check_flag("req_write", !e_load, mem_req_write);
        if (!e_load)
          check_val("req_wdata", e_idx[req_n] == 4'h8 ? link_register : rf[e_idx[req_n][2:0]], mem_req_wdata);
      end
      last_addr = mem_req_addr;
      req_n++;
    end
    if (!rst && (reg_wr_valid === 1'b1 || pc_wr_valid === 1'b1) && wb_ready)
    begin
      check_flag("wb_in_range", 1'b1, wb_n < exp_wb);
      if (wb_n < exp_wb)
      begin
        check_flag("pc_wr_valid", e_idx[wb_n] == 4'h8, pc_wr_valid);
        if (e_idx[wb_n] != 4'h8)
          check_val("reg_wr_idx", 32'(e_idx[wb_n][2:0]), 32'(reg_wr_idx));
        check_val("wb_data", mem_u.mem_word(e_base + 32'(4 * wb_n)), wb_data);
      end
      wb_n++;
    end
  end

  // Board-level stimulus: wb back-pressure is random only in slow mode
  always @(posedge core_clk)
  begin
    #1;
    wb_ready <= !slow || $random(seed) % 4 != 0;
  end

  // ----------------------------------------------------------------
  // One operation with its expectations
  // ----------------------------------------------------------------
  task automatic run_op(input logic ld, input logic [7:0] lst, input logic ex, input logic [31:0] sp,
                        input logic al, input int ab);
    int n;
    logic fault, aborted, d_abt, d_flt, d_spw;
    n = 0;
    for (int k = 0; k < 8; k++)
      if (lst[k])
      begin
        e_idx[n] = 4'(k);
        n++;
      end
    if (ex)
    begin
      e_idx[n] = 4'h8;
      n++;
    end
    fault = al && sp[1:0] != 2'b00;
    aborted = !fault && ab < n;
    total = n;
    req_n = 0;
    wb_n = 0;
    e_load = ld;
    e_base = {sp[31:2], 2'b00};
    exp_wb = (!ld || fault) ? 0 : (aborted ? ab : n);
    abort_addr = ab < n ? e_base + 32'(4 * ab) : 32'hFFFF_FFFF;
    for (int k = 0; k < 8; k++)
      rf[k] = $random(seed);
    link_register = $random(seed);
    op_valid = 1'b1;
    op_is_load = ld;
    reg_list = lst;
    extra_flag = ex;
    stack_pointer = sp;
    align_check_en = al;
    @(posedge core_clk);
    while (op_ready !== 1'b1)
      @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    reg_list = 8'($random(seed));
    @(posedge core_clk);
    while (op_done !== 1'b1)
      @(posedge core_clk);
    d_abt = op_abort;
    d_flt = op_align_fault;
    d_spw = sp_wr_en;
    #1;
    check_flag("op_align_fault", fault, d_flt);
    check_flag("op_abort", aborted, d_abt);
    check_flag("sp_wr_en", !fault && !aborted, d_spw);
    if (!fault && !aborted)
    begin
      check_val("sp_wr_data", sp + 32'(4 * n), sp_wr_data);
      check_val("access_count", 32'(n), 32'(req_n));
      if (n > 0)
        check_val("last_addr", e_base + 32'(4 * n) - 32'h0000_0004, last_addr);
    end
    if (fault)
      check_val("fault_accesses", 32'h0000_0000, 32'(req_n));
    check_val("wb_count", 32'(exp_wb), 32'(wb_n));
  endtask : run_op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      run_op(1'b1, 8'hFF, 1'b1, 32'h0000_1000, 1'b1, 99);
      run_op(1'b0, 8'hFF, 1'b1, 32'h0000_2000, 1'b0, 99);
      run_op(1'b0, 8'h00, 1'b0, 32'h0000_3000, 1'b0, 99);
      run_op(1'b1, 8'h00, 1'b1, 32'h0000_3004, 1'b0, 99);
      run_op(1'b1, 8'h81, 1'b0, 32'h0000_2003, 1'b0, 99);
      run_op(1'b0, 8'h0F, 1'b0, 32'h0000_2002, 1'b1, 99);
      run_op(1'b1, 8'h3C, 1'b1, 32'h0000_4000, 1'b0, 0);
      run_op(1'b1, 8'h3C, 1'b1, 32'h0000_4000, 1'b0, 4);
      run_op(1'b0, 8'h11, 1'b1, 32'h0000_5000, 1'b0, 1);
    end
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      slow = r[30];
      run_op(r[8], r[7:0], r[9], $random(seed), r[10], r[13:11] == 3'h0 ? int'(r[17:14]) : 99);
    end
    final_report();
  end
endmodule : test_stack_multi_transfer
